// File: setup_word_pkg.sv
/*
 * Constants and carriers for the nonvolatile identifier and interface setup words.
 * Assumes one 125 MHz system clock; the words are 16 bits wide.
 */
package setup_word_pkg;

    // ----------------------------------------------------------------
    // Word offsets in the nonvolatile image
    // ----------------------------------------------------------------
    localparam logic [1:0] ADDR_ID_LOW  = 2'h0;
    localparam logic [1:0] ADDR_ID_HIGH = 2'h1;
    localparam logic [1:0] ADDR_SETUP   = 2'h2;

    localparam logic [15:0] ID_LOW_RESET  = 16'h0000;
    localparam logic [15:0] ID_HIGH_RESET = 16'h0000;
    localparam logic [15:0] SETUP_RESET   = 16'h0000;

    // ----------------------------------------------------------------
    // Field positions inside the interface setup word
    // ----------------------------------------------------------------
    localparam int TADDR_LSB = 0;
    localparam int TADDR_W   = 7;
    localparam int INT_LSB   = 7;
    localparam int SSPOL_BIT = 9;
    localparam int CPHA_BIT  = 10;
    localparam int CPOL_BIT  = 11;
    localparam int CYC_LSB   = 12;
    localparam int SHAPE_BIT = 15;

    // Target address codes kept back for high speed entry
    localparam logic [6:0] HS_CODE_LOW  = 7'h04;
    localparam logic [6:0] HS_CODE_HIGH = 7'h07;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int CONDITIONED_RESULT_W        = 24;

    typedef enum logic [1:0] {
        INT_EOC    = 2'h0,
        INT_ABOVE  = 2'h1,
        INT_BELOW  = 2'h2,
        INT_WINDOW = 2'h3
    } int_mode_e;

    typedef enum logic [1:0] {
        LD_WAIT = 2'b01,
        LD_DONE = 2'b10
    } load_state_e;

    // Field order follows bit order of the setup word, so a cast decodes it
    typedef struct packed {
        logic        secondOrderShape;
        logic [2:0]  cyclicSleepPeriod;
        logic        cpol;
        logic        cpha;
        logic        ssActiveHigh;
        int_mode_e   intSetup;
        logic [6:0]  targetAddr;
    } setup_s;

    typedef struct packed {
        logic selActive;
        logic sampleStrobe;
        logic driveStrobe;
        logic mosiBit;
    } spi_link_s;

    // Sleep period in milliseconds per code; zero marks an unassigned code
    function automatic logic [12:0] cycMs(input logic [2:0] code);
        unique case (code)
            3'h1:    cycMs = 13'd125;
            3'h2:    cycMs = 13'd250;
            3'h3:    cycMs = 13'd500;
            3'h4:    cycMs = 13'd1000;
            3'h5:    cycMs = 13'd2000;
            3'h6:    cycMs = 13'd4000;
            default: cycMs = 13'd0;
        endcase
    endfunction

endpackage

// File: pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter for asynchronous pins.
 * Assumes pins may change at any time relative to ref_clk.
 */
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,  // System clock
    input  wire logic             rst,      // Async reset, active high
    input  wire logic [WIDTH-1:0] pinIn,    // Raw pin levels
    output logic      [WIDTH-1:0] pinOut    // Filtered levels
);
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1Reg;
            logic stage2Reg;
            logic stage3Reg;
            logic filtReg;
            logic filtNext;

            // A change counts only once the second and third stages agree
            always_comb begin
                filtNext = (stage2Reg == stage3Reg) ? stage3Reg : filtReg;
            end

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    stage1Reg <= 1'b0;
                    stage2Reg <= 1'b0;
                    stage3Reg <= 1'b0;
                    filtReg   <= 1'b0;
                end else begin
                    stage1Reg <= pinIn[i];
                    stage2Reg <= stage1Reg;
                    stage3Reg <= stage2Reg;
                    filtReg   <= filtNext;
                end
            end

            assign pinOut[i] = filtReg;
        end
    endgenerate
endmodule

// File: serial_interface_setup_word.sv
/*
 * Identifier words and interface setup word, with the decoded behaviour:
 * completion/threshold pin, select and clock edge detection, cyclic wake timer.
 * Assumes the nonvolatile image is presented on nvm* with nvmReady after reset,
 * and word reads/writes come from the command decoder on the mem* port.
 */
module serial_interface_setup_word #(
    parameter int MS_CYCLES = setup_word_pkg::MS_CYCLES
) (
    input  wire logic                              ref_clk,           // System clock
    input  wire logic                              rst,               // Async reset, high
    input  wire logic                              nvmReady,          // Image valid
    input  wire logic [15:0]                       nvmIdLow,          // Stored id low
    input  wire logic [15:0]                       nvmIdHigh,         // Stored id high
    input  wire logic [15:0]                       nvmSetup,          // Stored setup
    input  wire logic                              memWrEn,           // Word write pulse
    input  wire logic                              memRdEn,           // Word read pulse
    input  wire logic [1:0]                        memAddr,           // Word offset
    input  wire logic [15:0]                       memWrData,         // Write data
    output logic      [15:0]                       memRdData,         // Read data
    output logic                                   memRdValid,        // Read answer
    output logic                                   ifaceReady,        // Setup applied
    output logic      [31:0]                       customerId,        // Identifier
    output setup_word_pkg::setup_s                 setup,             // Decoded fields
    output logic                                   addrUsable,        // Address legal
    input  wire logic                              resultDone,        // Calc finished
    input  wire logic                              commandStart,      // New command
    input  wire logic [setup_word_pkg::CONDITIONED_RESULT_W-1:0] conditionedResult, // Result
    input  wire logic [setup_word_pkg::CONDITIONED_RESULT_W-1:0] thresholdOne,      // Threshold 1
    input  wire logic [setup_word_pkg::CONDITIONED_RESULT_W-1:0] thresholdTwo,      // Threshold 2
    output logic                                   eocPin,            // Completion pin
    input  wire logic                              sclkPin,           // SPI clock pin
    input  wire logic                              ssPin,             // SPI select pin
    input  wire logic                              mosiPin,           // SPI data in pin
    output setup_word_pkg::spi_link_s              spiLink,           // Link events
    input  wire logic                              cyclicRun,         // Cyclic enabled
    output logic                                   cycPeriodValid,    // Code assigned
    output logic                                   cyclicWake         // Wake pulse
);
    // ----------------------------------------------------------------
    // Word storage and power-up load
    // ----------------------------------------------------------------
    setup_word_pkg::load_state_e ldState_reg, ldState_next;
    logic [15:0] idLow_reg, idLow_next;
    logic [15:0] idHigh_reg, idHigh_next;
    logic [15:0] setup_reg, setup_next;
    logic [15:0] rdData_reg, rdData_next;
    logic        rdValid_reg, rdValid_next;
    logic        loaded;

    assign loaded = (ldState_reg == setup_word_pkg::LD_DONE);

    always_comb begin
        ldState_next = ldState_reg;
        idLow_next   = idLow_reg;
        idHigh_next  = idHigh_reg;
        setup_next   = setup_reg;
        rdData_next  = rdData_reg;
        rdValid_next = 1'b0;
        unique case (ldState_reg)
            setup_word_pkg::LD_WAIT: begin
                // Accesses are refused until the stored image is applied
                if (nvmReady) begin
                    idLow_next   = nvmIdLow;
                    idHigh_next  = nvmIdHigh;
                    setup_next   = nvmSetup;
                    ldState_next = setup_word_pkg::LD_DONE;
                end
            end
            setup_word_pkg::LD_DONE: begin
                if (memWrEn) begin
                    unique case (memAddr)
                        setup_word_pkg::ADDR_ID_LOW:  idLow_next  = memWrData;
                        setup_word_pkg::ADDR_ID_HIGH: idHigh_next = memWrData;
                        setup_word_pkg::ADDR_SETUP:   setup_next  = memWrData;
                        default: ;
                    endcase
                end
                if (memRdEn) begin
                    rdValid_next = 1'b1;
                    unique case (memAddr)
                        setup_word_pkg::ADDR_ID_LOW:  rdData_next = idLow_reg;
                        setup_word_pkg::ADDR_ID_HIGH: rdData_next = idHigh_reg;
                        setup_word_pkg::ADDR_SETUP:   rdData_next = setup_reg;
                        default:                      rdData_next = '0;
                    endcase
                end
            end
            default: ldState_next = setup_word_pkg::LD_WAIT;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ldState_reg <= setup_word_pkg::LD_WAIT;
            idLow_reg   <= setup_word_pkg::ID_LOW_RESET;
            idHigh_reg  <= setup_word_pkg::ID_HIGH_RESET;
            setup_reg   <= setup_word_pkg::SETUP_RESET;
            rdData_reg  <= '0;
            rdValid_reg <= 1'b0;
        end else begin
            ldState_reg <= ldState_next;
            idLow_reg   <= idLow_next;
            idHigh_reg  <= idHigh_next;
            setup_reg   <= setup_next;
            rdData_reg  <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    assign memRdData  = rdData_reg;
    assign memRdValid = rdValid_reg;
    assign ifaceReady = loaded;
    assign customerId = {idHigh_reg, idLow_reg};
    // Cast decodes address, interrupt, polarity, clock, period and shape
    assign setup      = setup_word_pkg::setup_s'(setup_reg);
    // Reserved codes are stored but flagged so address matching skips them
    assign addrUsable = loaded &&
                        !(setup.targetAddr >= setup_word_pkg::HS_CODE_LOW &&
                          setup.targetAddr <= setup_word_pkg::HS_CODE_HIGH);

    // ----------------------------------------------------------------
    // Completion / threshold pin
    // ----------------------------------------------------------------
    logic eoc_reg, eoc_next;
    logic above, below, inWindow;

    assign above = conditionedResult > thresholdOne;
    assign below = conditionedResult < thresholdOne;

    always_comb begin
        if (thresholdOne > thresholdTwo) begin
            inWindow = !(conditionedResult >= thresholdTwo && below);
        end else begin
            inWindow = (conditionedResult >= thresholdOne) &&
                       (conditionedResult < thresholdTwo);
        end
    end

    always_comb begin
        eoc_next = eoc_reg;
        unique case (setup.intSetup)
            setup_word_pkg::INT_EOC: begin
                // Completion in the same cycle as a new command wins
                if (resultDone) begin
                    eoc_next = 1'b1;
                end else if (commandStart) begin
                    eoc_next = 1'b0;
                end
            end
            setup_word_pkg::INT_ABOVE: begin
                // Equal to the threshold keeps the previous level
                if (resultDone && above) begin
                    eoc_next = 1'b1;
                end else if (resultDone && below) begin
                    eoc_next = 1'b0;
                end
            end
            setup_word_pkg::INT_BELOW: begin
                if (resultDone && below) begin
                    eoc_next = 1'b1;
                end else if (resultDone && above) begin
                    eoc_next = 1'b0;
                end
            end
            setup_word_pkg::INT_WINDOW: begin
                if (resultDone) begin
                    eoc_next = inWindow;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            eoc_reg <= 1'b0;
        end else begin
            eoc_reg <= eoc_next;
        end
    end

    assign eocPin = eoc_reg;

    // ----------------------------------------------------------------
    // SPI select and clock edge detection
    // ----------------------------------------------------------------
    logic [2:0] pinFilt;
    logic       sclkPrev_reg, sclkPrev_next;
    logic       selActive, latchOnRise, rise, fall;

    pin_sync #(.WIDTH(3)) u_pin_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pinIn   ({mosiPin, ssPin, sclkPin}),
        .pinOut  (pinFilt)
    );

    assign selActive   = loaded && (pinFilt[1] == setup.ssActiveHigh);
    // Modes 00 and 11 latch on rising, 01 and 10 on falling
    assign latchOnRise = !(setup.cpol ^ setup.cpha);
    assign rise        = pinFilt[0] && !sclkPrev_reg;
    assign fall        = !pinFilt[0] && sclkPrev_reg;

    always_comb begin
        sclkPrev_next = pinFilt[0];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclkPrev_reg <= 1'b0;
        end else begin
            sclkPrev_reg <= sclkPrev_next;
        end
    end

    always_comb begin
        spiLink.selActive    = selActive;
        spiLink.sampleStrobe = selActive && (latchOnRise ? rise : fall);
        spiLink.driveStrobe  = selActive && (latchOnRise ? fall : rise);
        spiLink.mosiBit      = pinFilt[2];
    end

    // ----------------------------------------------------------------
    // Cyclic wake timer: millisecond enable, then period count
    // ----------------------------------------------------------------
    logic [$clog2(MS_CYCLES)-1:0] msDiv_reg, msDiv_next;
    logic [12:0]                  msCnt_reg, msCnt_next;
    logic                         wake_reg, wake_next;
    logic [12:0]                  periodMs;
    logic                         msTick;

    assign periodMs       = setup_word_pkg::cycMs(setup.cyclicSleepPeriod);
    assign cycPeriodValid = (periodMs != 13'd0);
    assign msTick = (msDiv_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

    always_comb begin
        msDiv_next = msTick ? '0 : msDiv_reg + 1'b1;
        msCnt_next = msCnt_reg;
        wake_next  = 1'b0;
        if (!cyclicRun || !cycPeriodValid || !loaded) begin
            msDiv_next = '0;
            msCnt_next = '0;
        end else if (msTick) begin
            if (msCnt_reg == periodMs - 13'd1) begin
                msCnt_next = '0;
                wake_next  = 1'b1;
            end else begin
                msCnt_next = msCnt_reg + 13'd1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            msDiv_reg <= '0;
            msCnt_reg <= '0;
            wake_reg  <= 1'b0;
        end else begin
            msDiv_reg <= msDiv_next;
            msCnt_reg <= msCnt_next;
            wake_reg  <= wake_next;
        end
    end

    assign cyclicWake = wake_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_id_write_low: assert property (@(posedge ref_clk) disable iff (rst)
        (loaded && memWrEn && memAddr == setup_word_pkg::ADDR_ID_LOW)
        |=> customerId[15:0] == $past(memWrData)) else $error("id low not stored");
    a_hs_code_blocked: assert property (@(posedge ref_clk) disable iff (rst)
        addrUsable |-> !(setup.targetAddr inside {[7'h04:7'h07]}))
        else $error("reserved address usable");
    // Select may be active in the very cycle the load completes, so it is held to the
    // current ready level; the registered read answer always lags one cycle
    a_load_before_access: assert property (@(posedge ref_clk) disable iff (rst)
        (memRdValid |-> $past(ifaceReady)) and (spiLink.selActive |-> ifaceReady))
        else $error("access before load");
    a_eoc_done_set: assert property (@(posedge ref_clk) disable iff (rst)
        (resultDone && setup.intSetup == setup_word_pkg::INT_EOC && !memWrEn)
        |=> eocPin) else $error("completion not raised");
    a_eoc_cmd_clear: assert property (@(posedge ref_clk) disable iff (rst)
        (commandStart && !resultDone && setup.intSetup == setup_word_pkg::INT_EOC
         && !memWrEn) |=> !eocPin) else $error("completion not cleared");
    a_above_thresh: assert property (@(posedge ref_clk) disable iff (rst)
        (resultDone && setup.intSetup == setup_word_pkg::INT_ABOVE && !memWrEn)
        |=> eocPin == ($past(above) ? 1'b1 : $past(below) ? 1'b0 : $past(eocPin)))
        else $error("above mode wrong");
    a_below_thresh: assert property (@(posedge ref_clk) disable iff (rst)
        (resultDone && setup.intSetup == setup_word_pkg::INT_BELOW && !memWrEn
         && conditionedResult < thresholdOne) |=> eocPin) else $error("below mode wrong");
    a_window_level: assert property (@(posedge ref_clk) disable iff (rst)
        (resultDone && setup.intSetup == setup_word_pkg::INT_WINDOW && !memWrEn
         && thresholdOne > thresholdTwo && conditionedResult == thresholdTwo)
        |=> !eocPin) else $error("window level wrong");
    a_sample_edge: assert property (@(posedge ref_clk) disable iff (rst)
        spiLink.sampleStrobe |-> selActive &&
        (pinFilt[0] == !(setup.cpol ^ setup.cpha)))
        else $error("sample on wrong edge");
    a_wake_spacing: assert property (@(posedge ref_clk) disable iff (rst)
        cyclicWake |=> !cyclicWake [*2]) else $error("wake too close");
endmodule

// File: spi_host_model.sv
/*
 * Host-side SPI master model driving select, clock and data pins.
 * Assumes the bench calls idle() before frame(); link clock period 80 ns.
 */
module spi_host_model #(
    parameter int HALF_NS = 40
) (
    output logic sclkPin, // Link clock
    output logic ssPin,   // Select
    output logic mosiPin  // Data to device
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclkPin = 1'b0;
        ssPin   = 1'b1;
        mosiPin = 1'b0;
    end

    // Released data line shows the inverse of its last level, never a held value
    task automatic idle(input logic ssHigh, input logic cpol);
        ssPin   = !ssHigh;
        sclkPin = cpol;
        mosiPin = !mosiPin;
        #(4 * HALF_NS);
    endtask

    task automatic frame(input logic ssHigh, input logic cpha, input logic selOn,
                         input logic [7:0] tx);
        logic [23:0] cmd;
        // Commands always go out as three bytes, padded with zeros
        cmd   = {tx, 16'h0000};
        ssPin = selOn ? ssHigh : !ssHigh;
        #HALF_NS;
        for (int i = 0; i < 24; i++) begin
            if (!cpha) mosiPin = cmd[23 - i];
            #HALF_NS sclkPin = !sclkPin;
            if (cpha) mosiPin = cmd[23 - i];
            #HALF_NS sclkPin = !sclkPin;
        end
        #HALF_NS;
        ssPin   = !ssHigh;
        mosiPin = !mosiPin;
    endtask
endmodule

// File: tb_top.sv
/*
 * Self-checking bench for the identifier and interface setup words.
 * Assumes the word port, completion pin and a host SPI model at 80 ns.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC = 4;
    localparam logic [23:0] LO = 24'h32;
    localparam logic [23:0] HI = 24'h64;
    logic ref_clk, rst, nvmReady, memWrEn, memRdEn, resultDone, commandStart, cyclicRun;
    logic memRdValid, ifaceReady, addrUsable, eocPin, cycPeriodValid, cyclicWake;
    logic sclkPin, ssPin, mosiPin, firstSample, anySeen, pl, sel;
    logic [1:0] memAddr, md;
    logic [23:0] rx;
    logic [15:0] memWrData, memRdData;
    logic [23:0] res, thOne, thTwo;
    logic [31:0] customerId;
    setup_word_pkg::setup_s setup;
    setup_word_pkg::spi_link_s spiLink;
    int fail_count = 0, checked = 0, sCnt, dCnt, wCnt;

    serial_interface_setup_word #(.MS_CYCLES(MSC)) serial_interface_setup_word_inst (
        .ref_clk(ref_clk), .rst(rst), .nvmReady(nvmReady), .nvmIdLow(16'h1234),
        .nvmIdHigh(16'hABCD), .nvmSetup(16'h8045), .memWrEn(memWrEn), .memRdEn(memRdEn),
        .memAddr(memAddr), .memWrData(memWrData), .memRdData(memRdData),
        .memRdValid(memRdValid), .ifaceReady(ifaceReady), .customerId(customerId),
        .setup(setup), .addrUsable(addrUsable), .resultDone(resultDone),
        .commandStart(commandStart), .conditionedResult(res), .thresholdOne(thOne),
        .thresholdTwo(thTwo), .eocPin(eocPin), .sclkPin(sclkPin), .ssPin(ssPin),
        .mosiPin(mosiPin), .spiLink(spiLink), .cyclicRun(cyclicRun),
        .cycPeriodValid(cycPeriodValid), .cyclicWake(cyclicWake));
    spi_host_model spi_host_model_inst (.sclkPin(sclkPin), .ssPin(ssPin), .mosiPin(mosiPin));

    // ----------------------------------------------------------------
    // Clock, monitors and tasks
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Falling edge sampling keeps the counts clear of the design's update edge
    always @(negedge ref_clk) begin
        if (spiLink.sampleStrobe) begin
            sCnt++;
            rx = {rx[22:0], spiLink.mosiBit};
            if (!anySeen) firstSample = 1'b1;
        end
        if (spiLink.driveStrobe) dCnt++;
        anySeen = anySeen | spiLink.sampleStrobe | spiLink.driveStrobe;
        if (cyclicWake) wCnt++;
    end

    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        memAddr   <= a;
        memWrData <= d;
        memWrEn   <= 1'b1;
        @(posedge ref_clk);
        memWrEn <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [1:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        memAddr <= a;
        memRdEn <= 1'b1;
        @(posedge ref_clk);
        memRdEn <= 1'b0;
        #1;
        chk(memRdValid, 1'b1, "read answer");
        chk(memRdData, exp, "read data");
    endtask

    task automatic ev(input logic [1:0] m, input logic [23:0] r, input logic [23:0] t1,
                      input logic [23:0] t2, input logic e);
        wr(2'h2, {7'h00, m, 7'h10});
        @(posedge ref_clk);
        res        <= r;
        thOne      <= t1;
        thTwo      <= t2;
        resultDone <= 1'b1;
        @(posedge ref_clk);
        resultDone <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(eocPin, e, "completion pin");
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, memWrEn} = 2'h3;
        {nvmReady, memRdEn, resultDone, commandStart, cyclicRun} = 5'h00;
        {memAddr, memWrData, res, thOne, thTwo} = '0;
        memWrData = 16'hFFFF;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        memWrEn  <= 1'b0;
        nvmReady <= 1'b1;
        #1;
        chk(ifaceReady, 1'b0, "ready before image");
        for (int i = 0; i < 20 && ifaceReady !== 1'b1; i++) @(posedge ref_clk);
        if (ifaceReady !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        #1;
        chk(customerId, 32'hABCD_1234, "identifier after load");
        chk(setup, 16'h8045, "setup after load");
        rd(2'h0, 16'h1234);
        rd(2'h1, 16'hABCD);
        rd(2'h2, 16'h8045);
        rd(2'h3, 16'h0000);
        wr(2'h0, 16'h5A5A);
        chk(customerId, 32'hABCD_5A5A, "identifier pairing");
        $display("test words done");
        for (int a = 3; a <= 8; a++) begin
            wr(2'h2, 16'(a));
            chk(addrUsable, !(a >= 4 && a <= 7), "reserved address");
            chk(setup.targetAddr, a, "target address");
        end
        $display("test address done");
        for (int c = 0; c < 8; c++) begin
            @(posedge ref_clk);
            cyclicRun <= 1'b0;
            wr(2'h2, 16'(c) << 12);
            chk(cycPeriodValid, (c > 0 && c < 7), "period code");
            @(posedge ref_clk);
            cyclicRun <= 1'b1;
            wCnt = 0;
            repeat (1100) @(posedge ref_clk);
            chk(wCnt, (c > 0 && c < 7) ? 1100 / (125 * MSC << (c - 1)) : 0, "wakes");
        end
        cyclicRun <= 1'b0;
        $display("test cyclic done");
        ev(2'h0, HI, LO, LO, 1'b1);
        @(posedge ref_clk);
        commandStart <= 1'b1;
        @(posedge ref_clk);
        commandStart <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(eocPin, 1'b0, "cleared by command");
        // Completion and new command in one cycle: the set must win
        @(posedge ref_clk);
        {resultDone, commandStart} <= 2'h3;
        @(posedge ref_clk);
        {resultDone, commandStart} <= 2'h0;
        @(posedge ref_clk);
        #1;
        chk(eocPin, 1'b1, "set wins over clear");
        // Each step but the equal-to-threshold one flips the pin, so a stuck level cannot pass
        ev(2'h1, LO, HI, LO, 1'b0);
        ev(2'h1, 24'hC8, HI, LO, 1'b1);
        ev(2'h1, HI, HI, LO, 1'b1);
        ev(2'h2, 24'hC8, HI, LO, 1'b0);
        ev(2'h2, LO, HI, LO, 1'b1);
        ev(2'h3, LO, HI, LO, 1'b0);
        ev(2'h3, HI, HI, LO, 1'b1);
        ev(2'h3, HI - 1, HI, LO, 1'b0);
        ev(2'h3, LO - 1, HI, LO, 1'b1);
        ev(2'h3, LO - 1, LO, HI, 1'b0);
        ev(2'h3, LO, LO, HI, 1'b1);
        ev(2'h3, HI, LO, HI, 1'b0);
        ev(2'h3, HI - 1, LO, HI, 1'b1);
        ev(2'h3, LO, LO, LO, 1'b0);
        $display("test completion pin done");
        for (int m = 0; m < 5; m++) begin
            md  = 2'(m);
            sel = (m < 4);
            pl  = md[0] ^ md[1];
            wr(2'h2, {4'h0, md, pl, 9'h010});
            spi_host_model_inst.idle(pl, md[1]);
            @(posedge ref_clk);
            {sCnt, dCnt, anySeen, firstSample} = '0;
            spi_host_model_inst.frame(pl, md[0], sel, 8'hA6);
            repeat (12) @(posedge ref_clk);
            chk(sCnt, sel ? 24 : 0, "sample strobes");
            chk(dCnt, sel ? 24 : 0, "drive strobes");
            chk(firstSample, sel & !md[0], "first edge kind");
            if (sel) chk(rx, 24'hA6_0000, "received command");
        end
        $display("test link done");
        wrap_up();
    end
endmodule
